/* common/line_driver_pkg.sv */
`default_nettype none
package line_driver_pkg;
  // ==========================================================
  // Register offsets (bit 7 of the address byte selects read)
  localparam logic [6:0] ADDR_MAIN_CFG   = 7'h56;
  localparam logic [6:0] ADDR_MAIN_LIM   = 7'h57;
  localparam logic [6:0] ADDR_AUX_CFG    = 7'h58;
  localparam logic [6:0] ADDR_AUX_LIM    = 7'h59;
  localparam logic [6:0] ADDR_SRC_SEL    = 7'h5a;
  localparam logic [6:0] ADDR_LIMIT_DIS  = 7'h60;
  localparam logic [6:0] ADDR_FAULT_STAT = 7'h61;
  localparam logic [7:0] REG_RESET       = 8'h00;
  // ==========================================================
  // Field positions of the config registers (main and aux alike)
  localparam int CFG_SLEW_LO = 6;
  localparam int CFG_PD      = 5;
  localparam int CFG_PU      = 4;
  localparam int CFG_SINK    = 3;
  localparam int CFG_PP      = 2;
  localparam int CFG_INV     = 1;
  localparam int CFG_EN      = 0;
  // Field positions of the limit and retry registers
  localparam int LIM_LEVEL_LO = 6;
  localparam int LIM_BLANK_LO = 3;
  localparam int LIM_OFF_LO   = 1;
  localparam int LIM_RETRY    = 0;
  // Field positions of the source select register
  localparam int SRC_MAIN_LEVEL = 7;
  localparam int SRC_MAIN_EN    = 6;
  localparam int SRC_MAIN_SEL   = 5;
  localparam int SRC_AUX_LEVEL  = 4;
  localparam int SRC_AUX_SEL    = 3;
  localparam int SRC_TRACK      = 1;
  localparam int SRC_ANTIVAL    = 0;
  // Limit disable and fault status bits
  localparam int DIS_MAIN   = 1;
  localparam int DIS_AUX    = 0;
  localparam int STAT_MAIN  = 1;
  localparam int STAT_AUX   = 0;
  // ==========================================================
  // Timing: all guard timers count a 1 us tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TIMER_W       = 19;
  localparam logic [18:0] BLANK_US_0 = 19'd128;
  localparam logic [18:0] BLANK_US_1 = 19'd500;
  localparam logic [18:0] BLANK_US_2 = 19'd1000;
  localparam logic [18:0] BLANK_US_3 = 19'd5000;
  localparam logic [18:0] OFF_US_0   = 19'd50000;
  localparam logic [18:0] OFF_US_1   = 19'd100000;
  localparam logic [18:0] OFF_US_2   = 19'd200000;
  localparam logic [18:0] OFF_US_3   = 19'd500000;
  localparam int SPI_BITS = 16;
  typedef enum logic [3:0] {
    G_IDLE  = 4'b0001,
    G_BLANK = 4'b0010,
    G_RETRY = 4'b0100,
    G_HELD  = 4'b1000
  } guard_state_t;
endpackage
`default_nettype wire

/* src/fault_guard.sv */
`default_nettype none
module fault_guard (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       tick_in,
  // Driver side
  input  wire logic       active_in,
  input  wire logic       overcurrent_in,
  input  wire logic [1:0] blank_sel_in,
  input  wire logic       retry_on_in,
  input  wire logic [1:0] retry_sel_in,
  input  wire logic       rearm_in,
  // Results
  output logic            drive_ok_out,
  output logic            fault_out
);
  line_driver_pkg::guard_state_t state_q;
  logic [18:0] count_q;

  function automatic logic [18:0] blank_limit(input logic [1:0] s);
    unique case (s)
      2'b00: blank_limit = line_driver_pkg::BLANK_US_0;
      2'b01: blank_limit = line_driver_pkg::BLANK_US_1;
      2'b10: blank_limit = line_driver_pkg::BLANK_US_2;
      2'b11: blank_limit = line_driver_pkg::BLANK_US_3;
    endcase
  endfunction

  function automatic logic [18:0] off_limit(input logic [1:0] s);
    unique case (s)
      2'b00: off_limit = line_driver_pkg::OFF_US_0;
      2'b01: off_limit = line_driver_pkg::OFF_US_1;
      2'b10: off_limit = line_driver_pkg::OFF_US_2;
      2'b11: off_limit = line_driver_pkg::OFF_US_3;
    endcase
  endfunction

  // ==========================================================
  // Blanking, off time and latch-off
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_q <= line_driver_pkg::G_IDLE;
      count_q <= '0;
      fault_out <= 1'b0;
    end else begin
      fault_out <= 1'b0;
      unique case (state_q)
        line_driver_pkg::G_IDLE: begin
          count_q <= '0;
          if (active_in && overcurrent_in) begin
            state_q <= line_driver_pkg::G_BLANK;
          end
        end
        line_driver_pkg::G_BLANK: begin
          // Any drop of the indication restarts the blanking
          if (!overcurrent_in || !active_in) begin // [RL21]
            state_q <= line_driver_pkg::G_IDLE;
            count_q <= '0;
          end else if (count_q >= blank_limit(blank_sel_in)) begin // [RL8] [RL13]
            fault_out <= 1'b1;
            count_q <= '0;
            state_q <= retry_on_in ? line_driver_pkg::G_RETRY : line_driver_pkg::G_HELD;
          end else if (tick_in) begin
            count_q <= count_q + 19'd1;
          end
        end
        line_driver_pkg::G_RETRY: begin
          if (count_q >= off_limit(retry_sel_in)) begin // [RL9] [RL14]
            state_q <= line_driver_pkg::G_IDLE;
            count_q <= '0;
          end else if (tick_in) begin // [RL21]
            count_q <= count_q + 19'd1;
          end
        end
        line_driver_pkg::G_HELD: begin
          if (rearm_in) begin // [RL22]
            state_q <= line_driver_pkg::G_IDLE;
          end
        end
      endcase
    end
  end

  assign drive_ok_out = (state_q == line_driver_pkg::G_IDLE) || (state_q == line_driver_pkg::G_BLANK);
endmodule // fault_guard
`default_nettype wire

/* src/line_driver_control.sv */
// Function
// [RL1] Aux slew code, ignored under limit disable
// [RL2] Main slew code, ignored under limit disable
// [RL3] Main weak pull-down bit 5, pull-up bit 4
// [RL4] Main push-pull, else sink; link forces push-pull
// [RL5] Main line inverts pins unless invert set
// [RL6] Main driver on only with enable bit
// [RL7] Main limit level code when limit enabled
// [RL8] Main overcurrent past blanking: fault, interrupt
// [RL9] Main auto-retry re-enables after off time
// [RL10] Aux push-pull, sink mode, weak pulls
// [RL11] Aux line inverts input pin unless invert
// [RL12] Aux driver on only with enable bit
// [RL13] Aux overcurrent past blanking: fault, interrupt
// [RL14] Aux auto-retry re-enables after off time
// [RL15] Main source: pins or register bits
// [RL16] Main soft level and soft enable
// [RL17] Aux source: pin or soft level
// [RL18] Tracking makes aux follow main source
// [RL19] Antivalent sets aux polarity under tracking
// [RL20] Host sets tracking with antivalent
// [RL21] Blanking restarts; timers use common tick
// [RL22] Held fault until enable rewrite; sticky status
`default_nettype none
module line_driver_control #(
  parameter int TICK_CYCLES = line_driver_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RESETN_IN,
  // Serial host port
  input  wire logic       SPI_CS_N_IN,
  input  wire logic       SPI_SCLK_IN,
  input  wire logic       SPI_SDI_IN,
  output logic            SPI_SDO_OUT,
  output logic            SPI_SDO_OE_OUT,
  // Driver pins and status
  input  wire logic       DRIVER_ENABLE_PIN_IN,
  input  wire logic       TX_DATA_IN,
  input  wire logic       AUX_DRIVE_INPUT_PIN_IN,
  input  wire logic       LINK_MODE_IN,
  input  wire logic       MAIN_OVERCURRENT_IN,
  input  wire logic       AUX_OVERCURRENT_IN,
  // Main driver stage
  output logic            MAIN_DRIVE_EN_OUT,
  output logic            MAIN_LEVEL_OUT,
  output logic            MAIN_PUSH_PULL_OUT,
  output logic            MAIN_SINK_MODE_OUT,
  output logic [1:0]      MAIN_SLEW_OUT,
  output logic [1:0]      MAIN_LIMIT_LEVEL_OUT,
  output logic            MAIN_LIMIT_ON_OUT,
  output logic            MAIN_PULLUP_OUT,
  output logic            MAIN_PULLDOWN_OUT,
  // Aux driver stage
  output logic            AUX_DRIVE_EN_OUT,
  output logic            AUX_LEVEL_OUT,
  output logic            AUX_PUSH_PULL_OUT,
  output logic            AUX_SINK_MODE_OUT,
  output logic [1:0]      AUX_SLEW_OUT,
  output logic [1:0]      AUX_LIMIT_LEVEL_OUT,
  output logic            AUX_LIMIT_ON_OUT,
  output logic            AUX_PULLUP_OUT,
  output logic            AUX_PULLDOWN_OUT,
  // Interrupt
  output logic            IRQ_N_OUT
);
  // ==========================================================
  // Registers
  logic [7:0] main_cfg_q;
  logic [7:0] main_lim_q;
  logic [7:0] aux_cfg_q;
  logic [7:0] aux_lim_q;
  logic [7:0] src_sel_q;
  logic [1:0] limit_dis_q;
  logic [1:0] fault_stat_q;

  // Serial port state
  logic       sclk_prev_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_in_q;
  logic [6:0] addr_q;
  logic       rd_q;
  logic       load_q;
  logic [7:0] shift_out_q;
  logic       wr_q;
  logic [6:0] wr_addr_q;
  logic [7:0] wr_data_q;

  logic       sclk_rise;
  logic       sclk_fall;
  assign sclk_rise = SPI_SCLK_IN && !sclk_prev_q;
  assign sclk_fall = !SPI_SCLK_IN && sclk_prev_q;

  function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] mc, input logic [7:0] ml,
                                          input logic [7:0] ac, input logic [7:0] al, input logic [7:0] ss,
                                          input logic [1:0] ld, input logic [1:0] fs);
    unique case (a)
      line_driver_pkg::ADDR_MAIN_CFG:   read_mux = mc;
      line_driver_pkg::ADDR_MAIN_LIM:   read_mux = ml;
      line_driver_pkg::ADDR_AUX_CFG:    read_mux = ac;
      line_driver_pkg::ADDR_AUX_LIM:    read_mux = al;
      line_driver_pkg::ADDR_SRC_SEL:    read_mux = ss;
      line_driver_pkg::ADDR_LIMIT_DIS:  read_mux = {6'h00, ld};
      line_driver_pkg::ADDR_FAULT_STAT: read_mux = {6'h00, fs};
      default:                          read_mux = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Serial frame: address byte (bit 7 = read), then data byte
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q   <= 5'h00;
      shift_in_q  <= 8'h00;
      addr_q      <= 7'h00;
      rd_q        <= 1'b0;
      load_q      <= 1'b0;
      wr_q        <= 1'b0;
      wr_addr_q   <= 7'h00;
      wr_data_q   <= 8'h00;
    end else begin
      sclk_prev_q <= SPI_SCLK_IN;
      load_q      <= 1'b0;
      wr_q        <= 1'b0;
      if (SPI_CS_N_IN) begin
        bit_cnt_q <= 5'h00;
        rd_q      <= 1'b0;
      end else if (sclk_rise && bit_cnt_q < 5'(line_driver_pkg::SPI_BITS)) begin
        shift_in_q <= {shift_in_q[6:0], SPI_SDI_IN};
        bit_cnt_q  <= bit_cnt_q + 5'h01;
        if (bit_cnt_q == 5'h07) begin
          addr_q <= {shift_in_q[5:0], SPI_SDI_IN};
          rd_q   <= shift_in_q[6];
          load_q <= shift_in_q[6];
        end
        if (bit_cnt_q == 5'h0f && !rd_q) begin
          wr_q      <= 1'b1;
          wr_addr_q <= addr_q;
          wr_data_q <= {shift_in_q[6:0], SPI_SDI_IN};
        end
      end
    end
  end

  // Read data shifts out on falling edges, needs a half period of two clocks
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      shift_out_q    <= 8'h00;
      SPI_SDO_OUT    <= 1'b0;
      SPI_SDO_OE_OUT <= 1'b0;
    end else begin
      SPI_SDO_OE_OUT <= !SPI_CS_N_IN && rd_q;
      if (load_q) begin
        shift_out_q <= read_mux(addr_q, main_cfg_q, main_lim_q, aux_cfg_q, aux_lim_q, src_sel_q,
                                limit_dis_q, fault_stat_q);
      end else if (sclk_fall && rd_q && !SPI_CS_N_IN) begin
        SPI_SDO_OUT <= shift_out_q[7];
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Register file
  logic main_rearm;
  logic aux_rearm;
  assign main_rearm = wr_q && wr_addr_q == line_driver_pkg::ADDR_MAIN_CFG;
  assign aux_rearm  = wr_q && wr_addr_q == line_driver_pkg::ADDR_AUX_CFG;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      main_cfg_q  <= line_driver_pkg::REG_RESET;
      main_lim_q  <= line_driver_pkg::REG_RESET;
      aux_cfg_q   <= line_driver_pkg::REG_RESET;
      aux_lim_q   <= line_driver_pkg::REG_RESET;
      src_sel_q   <= line_driver_pkg::REG_RESET;
      limit_dis_q <= 2'b00;
    end else if (wr_q) begin
      unique case (wr_addr_q)
        line_driver_pkg::ADDR_MAIN_CFG:  main_cfg_q  <= wr_data_q;
        line_driver_pkg::ADDR_MAIN_LIM:  main_lim_q  <= wr_data_q & 8'hdf;
        line_driver_pkg::ADDR_AUX_CFG:   aux_cfg_q   <= wr_data_q;
        line_driver_pkg::ADDR_AUX_LIM:   aux_lim_q   <= wr_data_q & 8'hdf;
        line_driver_pkg::ADDR_SRC_SEL:   src_sel_q   <= wr_data_q & 8'hfb;
        line_driver_pkg::ADDR_LIMIT_DIS: limit_dis_q <= wr_data_q[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Fault timers share one tick so both lines see the same time base
  logic [7:0] tick_cnt_q;
  logic       tick_q;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= 8'(TICK_CYCLES - 1)) begin // [RL21]
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
      tick_q     <= 1'b0;
    end
  end

  logic main_ok;
  logic aux_ok;
  logic main_fault;
  logic aux_fault;

  fault_guard u_main_guard (
    .clk_in         (CLK_SYS_IN),
    .resetn_in      (RESETN_IN),
    .tick_in        (tick_q),
    .active_in      (MAIN_DRIVE_EN_OUT),
    .overcurrent_in (MAIN_OVERCURRENT_IN),
    .blank_sel_in   (main_lim_q[line_driver_pkg::LIM_BLANK_LO +: 2]),
    .retry_on_in    (main_lim_q[line_driver_pkg::LIM_RETRY]),
    .retry_sel_in   (main_lim_q[line_driver_pkg::LIM_OFF_LO +: 2]),
    .rearm_in       (main_rearm),
    .drive_ok_out   (main_ok),
    .fault_out      (main_fault)
  );

  fault_guard u_aux_guard (
    .clk_in         (CLK_SYS_IN),
    .resetn_in      (RESETN_IN),
    .tick_in        (tick_q),
    .active_in      (AUX_DRIVE_EN_OUT),
    .overcurrent_in (AUX_OVERCURRENT_IN),
    .blank_sel_in   (aux_lim_q[line_driver_pkg::LIM_BLANK_LO +: 2]),
    .retry_on_in    (aux_lim_q[line_driver_pkg::LIM_RETRY]),
    .retry_sel_in   (aux_lim_q[line_driver_pkg::LIM_OFF_LO +: 2]),
    .rearm_in       (aux_rearm),
    .drive_ok_out   (aux_ok),
    .fault_out      (aux_fault)
  );

  // Sticky fault status, write one to clear; a new fault wins the clear
  logic [1:0] stat_clr;
  assign stat_clr = (wr_q && wr_addr_q == line_driver_pkg::ADDR_FAULT_STAT) ? wr_data_q[1:0] : 2'b00;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      fault_stat_q <= 2'b00;
      IRQ_N_OUT    <= 1'b1;
    end else begin
      fault_stat_q <= (fault_stat_q & ~stat_clr) | {main_fault, aux_fault}; // [RL22]
      IRQ_N_OUT    <= !(|fault_stat_q); // [RL8] [RL13]
    end
  end

  // ==========================================================
  // Line steering
  logic main_src;
  logic main_en_d;
  logic aux_src;
  logic aux_high_d;
  always_comb begin
    main_src  = src_sel_q[line_driver_pkg::SRC_MAIN_SEL] ? src_sel_q[line_driver_pkg::SRC_MAIN_LEVEL]
                                                          : TX_DATA_IN; // [RL15] [RL16]
    main_en_d = main_cfg_q[line_driver_pkg::CFG_EN] && main_ok &&
                (src_sel_q[line_driver_pkg::SRC_MAIN_SEL] ? src_sel_q[line_driver_pkg::SRC_MAIN_EN]
                                                          : DRIVER_ENABLE_PIN_IN); // [RL6] [RL15] [RL16]
    aux_src   = src_sel_q[line_driver_pkg::SRC_AUX_SEL] ? src_sel_q[line_driver_pkg::SRC_AUX_LEVEL]
                                                         : AUX_DRIVE_INPUT_PIN_IN; // [RL17]
    // Tracking follows the main source; antivalent alone has no effect
    if (src_sel_q[line_driver_pkg::SRC_TRACK]) begin // [RL18]
      aux_high_d = src_sel_q[line_driver_pkg::SRC_ANTIVAL] ? main_src : !main_src; // [RL19]
    end else begin
      aux_high_d = aux_src ^ !aux_cfg_q[line_driver_pkg::CFG_INV]; // [RL11] [RL17]
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      MAIN_DRIVE_EN_OUT  <= 1'b0;
      MAIN_LEVEL_OUT     <= 1'b0;
      MAIN_PUSH_PULL_OUT <= 1'b0;
      MAIN_SINK_MODE_OUT <= 1'b0;
      MAIN_PULLUP_OUT    <= 1'b0;
      MAIN_PULLDOWN_OUT  <= 1'b0;
    end else begin
      MAIN_DRIVE_EN_OUT  <= main_en_d; // [RL6] [RL8] [RL9]
      MAIN_LEVEL_OUT     <= main_src ^ !main_cfg_q[line_driver_pkg::CFG_INV]; // [RL5] [RL16]
      MAIN_PUSH_PULL_OUT <= LINK_MODE_IN || main_cfg_q[line_driver_pkg::CFG_PP]; // [RL4]
      MAIN_SINK_MODE_OUT <= !LINK_MODE_IN && !main_cfg_q[line_driver_pkg::CFG_PP] &&
                            main_cfg_q[line_driver_pkg::CFG_SINK]; // [RL4]
      MAIN_PULLUP_OUT    <= main_cfg_q[line_driver_pkg::CFG_PU]; // [RL3]
      MAIN_PULLDOWN_OUT  <= main_cfg_q[line_driver_pkg::CFG_PD]; // [RL3]
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      AUX_DRIVE_EN_OUT  <= 1'b0;
      AUX_LEVEL_OUT     <= 1'b0;
      AUX_PUSH_PULL_OUT <= 1'b0;
      AUX_SINK_MODE_OUT <= 1'b0;
      AUX_PULLUP_OUT    <= 1'b0;
      AUX_PULLDOWN_OUT  <= 1'b0;
    end else begin
      AUX_DRIVE_EN_OUT  <= aux_cfg_q[line_driver_pkg::CFG_EN] && aux_ok; // [RL12] [RL13] [RL14]
      AUX_LEVEL_OUT     <= aux_high_d;
      AUX_PUSH_PULL_OUT <= aux_cfg_q[line_driver_pkg::CFG_PP]; // [RL10]
      AUX_SINK_MODE_OUT <= !aux_cfg_q[line_driver_pkg::CFG_PP] && aux_cfg_q[line_driver_pkg::CFG_SINK]; // [RL10]
      AUX_PULLUP_OUT    <= aux_cfg_q[line_driver_pkg::CFG_PU]; // [RL10]
      AUX_PULLDOWN_OUT  <= aux_cfg_q[line_driver_pkg::CFG_PD]; // [RL10]
    end
  end

  // Slew outputs drive 00 while the limit is disabled; register reads keep the written code
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      MAIN_SLEW_OUT        <= 2'b00;
      MAIN_LIMIT_LEVEL_OUT <= 2'b00;
      MAIN_LIMIT_ON_OUT    <= 1'b0;
      AUX_SLEW_OUT         <= 2'b00;
      AUX_LIMIT_LEVEL_OUT  <= 2'b00;
      AUX_LIMIT_ON_OUT     <= 1'b0;
    end else begin
      MAIN_SLEW_OUT        <= limit_dis_q[line_driver_pkg::DIS_MAIN] ? 2'b00
                              : main_cfg_q[line_driver_pkg::CFG_SLEW_LO +: 2]; // [RL2]
      MAIN_LIMIT_LEVEL_OUT <= main_lim_q[line_driver_pkg::LIM_LEVEL_LO +: 2]; // [RL7]
      MAIN_LIMIT_ON_OUT    <= !limit_dis_q[line_driver_pkg::DIS_MAIN]; // [RL7]
      AUX_SLEW_OUT         <= limit_dis_q[line_driver_pkg::DIS_AUX] ? 2'b00
                              : aux_cfg_q[line_driver_pkg::CFG_SLEW_LO +: 2]; // [RL1]
      AUX_LIMIT_LEVEL_OUT  <= aux_lim_q[line_driver_pkg::LIM_LEVEL_LO +: 2];
      AUX_LIMIT_ON_OUT     <= !limit_dis_q[line_driver_pkg::DIS_AUX];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  a_main_enable_gate: assert property ( // [RL6]
    !main_cfg_q[0] |=> !MAIN_DRIVE_EN_OUT) else $error("main driver on while enable bit clear");
  a_aux_enable_gate: assert property ( // [RL12]
    !aux_cfg_q[0] |=> !AUX_DRIVE_EN_OUT) else $error("aux driver on while enable bit clear");
  a_link_push_pull: assert property ( // [RL4]
    LINK_MODE_IN |=> MAIN_PUSH_PULL_OUT && !MAIN_SINK_MODE_OUT) else $error("link mode not push-pull");
  a_main_pin_level: assert property ( // [RL5]
    !src_sel_q[5] |=> MAIN_LEVEL_OUT == ($past(TX_DATA_IN) ^ !$past(main_cfg_q[1])))
    else $error("main level wrong from pin");
  a_main_soft_level: assert property ( // [RL16]
    src_sel_q[5] && main_cfg_q[1] == 1'b0 |=> MAIN_LEVEL_OUT == !$past(src_sel_q[7]))
    else $error("main soft level wrong");
  a_track_polarity: assert property ( // [RL19]
    src_sel_q[1] && !src_sel_q[5] |=> AUX_LEVEL_OUT == ($past(TX_DATA_IN) ~^ $past(src_sel_q[0])))
    else $error("tracking polarity wrong");
  a_fault_drop_irq: assert property ( // [RL8]
    main_fault |=> !MAIN_DRIVE_EN_OUT ##1 !IRQ_N_OUT) else $error("main fault not acted on");
  a_slew_limit_off: assert property ( // [RL1]
    limit_dis_q[0] |=> AUX_SLEW_OUT == 2'b00) else $error("aux slew not ignored");
  a_fault_sticky: assert property ( // [RL22]
    aux_fault |=> fault_stat_q[0] [*2]) else $error("aux fault status lost");

  c_main_fault: cover property (main_fault ##[1:1000] main_ok);
  c_aux_fault:  cover property (aux_fault);
  c_tracking:   cover property (src_sel_q[1] && src_sel_q[0] && AUX_DRIVE_EN_OUT);
endmodule // line_driver_control
`default_nettype wire

/* verif/line_load_model.sv */
`default_nettype none
module line_load_model (
  // Line state
  input  wire logic drive_en_in,
  input  wire logic short_in,
  // Load current sense
  output logic      overcurrent_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Load
  // A shorted line draws excess current only while it is driven
  assign overcurrent_out = drive_en_in & short_in;
endmodule // line_load_model
`default_nettype wire

/* verif/line_driver_control_tb_top.sv */
`default_nettype none
module line_driver_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic CLK_SYS_IN = 1'b0, RESETN_IN = 1'b0, SPI_CS_N_IN = 1'b1, SPI_SCLK_IN = 1'b0, SPI_SDI_IN = 1'b0;
  logic DRIVER_ENABLE_PIN_IN = 1'b0, TX_DATA_IN = 1'b0, AUX_DRIVE_INPUT_PIN_IN = 1'b0, LINK_MODE_IN = 1'b0;
  logic MAIN_OVERCURRENT_IN, AUX_OVERCURRENT_IN, short_main = 1'b0, short_aux = 1'b0;
  logic SPI_SDO_OUT, SPI_SDO_OE_OUT, MAIN_DRIVE_EN_OUT, MAIN_LEVEL_OUT, MAIN_PUSH_PULL_OUT, MAIN_SINK_MODE_OUT;
  logic MAIN_LIMIT_ON_OUT, MAIN_PULLUP_OUT, MAIN_PULLDOWN_OUT, AUX_DRIVE_EN_OUT, AUX_LEVEL_OUT, AUX_PUSH_PULL_OUT;
  logic AUX_SINK_MODE_OUT, AUX_LIMIT_ON_OUT, AUX_PULLUP_OUT, AUX_PULLDOWN_OUT, IRQ_N_OUT;
  logic [1:0] MAIN_SLEW_OUT, MAIN_LIMIT_LEVEL_OUT, AUX_SLEW_OUT, AUX_LIMIT_LEVEL_OUT;
  logic [7:0] rd;
  logic oe_seen;
  int fails = 0, comparisons = 0;
  // Rows: main cfg, source, aux cfg, {enable pin, tx, aux pin, link}, expected outputs
  localparam logic [43:0] ROWS [9] = '{44'h0100018_0c30, 44'h5b00a6e_6d99, 44'he00019d_c276,
    44'h01f8010_0820, 44'h032003e_0030, 44'h010203c_0820, 44'h010303c_0830, 44'h010101e_0820, 44'h0100000_0410};
  // ==========================================================
  // Design and loads
  line_driver_control #(.TICK_CYCLES(1)) u_line_driver_control (.CLK_SYS_IN, .RESETN_IN, .SPI_CS_N_IN,
    .SPI_SCLK_IN, .SPI_SDI_IN, .SPI_SDO_OUT, .SPI_SDO_OE_OUT, .DRIVER_ENABLE_PIN_IN, .TX_DATA_IN,
    .AUX_DRIVE_INPUT_PIN_IN, .LINK_MODE_IN, .MAIN_OVERCURRENT_IN, .AUX_OVERCURRENT_IN, .MAIN_DRIVE_EN_OUT,
    .MAIN_LEVEL_OUT, .MAIN_PUSH_PULL_OUT, .MAIN_SINK_MODE_OUT, .MAIN_SLEW_OUT, .MAIN_LIMIT_LEVEL_OUT,
    .MAIN_LIMIT_ON_OUT, .MAIN_PULLUP_OUT, .MAIN_PULLDOWN_OUT, .AUX_DRIVE_EN_OUT, .AUX_LEVEL_OUT,
    .AUX_PUSH_PULL_OUT, .AUX_SINK_MODE_OUT, .AUX_SLEW_OUT, .AUX_LIMIT_LEVEL_OUT, .AUX_LIMIT_ON_OUT,
    .AUX_PULLUP_OUT, .AUX_PULLDOWN_OUT, .IRQ_N_OUT);
  line_load_model u_line_load_model_main (.drive_en_in(MAIN_DRIVE_EN_OUT), .short_in(short_main),
    .overcurrent_out(MAIN_OVERCURRENT_IN));
  line_load_model u_line_load_model_aux (.drive_en_in(AUX_DRIVE_EN_OUT), .short_in(short_aux),
    .overcurrent_out(AUX_OVERCURRENT_IN));
  wire logic [15:0] obs = {MAIN_SLEW_OUT, AUX_SLEW_OUT, MAIN_DRIVE_EN_OUT, MAIN_LEVEL_OUT, MAIN_PUSH_PULL_OUT,
    MAIN_SINK_MODE_OUT, MAIN_PULLUP_OUT, MAIN_PULLDOWN_OUT, AUX_DRIVE_EN_OUT, AUX_LEVEL_OUT, AUX_PUSH_PULL_OUT,
    AUX_SINK_MODE_OUT, AUX_PULLUP_OUT, AUX_PULLDOWN_OUT};
  always #5 CLK_SYS_IN = ~CLK_SYS_IN;
  // ==========================================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK_SYS_IN);
  endtask
  // Serial clock halves of 3 cycles meet the sampling limit with one cycle to spare
  task automatic spi(input logic [15:0] w, output logic [7:0] r);
    SPI_CS_N_IN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      SPI_SDI_IN = w[i];
      SPI_SCLK_IN = 1'b0;
      cyc(3);
      if (i < 8) begin
        r[i] = SPI_SDO_OUT;
        oe_seen = SPI_SDO_OE_OUT;
      end
      SPI_SCLK_IN = 1'b1;
      cyc(3);
    end
    SPI_SCLK_IN = 1'b0;
    cyc(3);
    SPI_CS_N_IN = 1'b1;
    cyc(4);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    spi({1'b0, a, d}, dummy);
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Watchdog
  initial begin
    #700us;
    fails++;
    final_report();
  end
  // ==========================================================
  // Main sequence
  initial begin
    cyc(3);
    chk("reset outputs", {obs[14:0], IRQ_N_OUT}, 16'h0001);
    RESETN_IN = 1'b1;
    foreach (ROWS[k]) begin
      wr(7'h56, ROWS[k][43:36]);
      wr(7'h58, ROWS[k][27:20]);
      wr(7'h5a, ROWS[k][35:28]);
      {DRIVER_ENABLE_PIN_IN, TX_DATA_IN, AUX_DRIVE_INPUT_PIN_IN, LINK_MODE_IN} = ROWS[k][19:16];
      cyc(2);
      chk("main row", obs & 16'hcfc0, ROWS[k][15:0] & 16'hcfc0);
      chk("aux row", obs & 16'h303f, ROWS[k][15:0] & 16'h303f);
    end
    wr(7'h57, 8'hff);
    spi({1'b1, 7'h57, 8'h00}, rd);
    chk("limit readback", rd, 8'hdf);
    chk("sdo enable read", oe_seen, 1'b1);
    chk("limit level", {MAIN_LIMIT_LEVEL_OUT, MAIN_LIMIT_ON_OUT}, 3'b111);
    spi({1'b1, 7'h5b, 8'h00}, rd);
    chk("unmapped read", rd, 8'h00);
    wr(7'h60, 8'h02);
    chk("sdo enable write", oe_seen, 1'b0);
    wr(7'h56, 8'hc1);
    chk("limit disabled", {MAIN_SLEW_OUT, MAIN_LIMIT_ON_OUT}, 3'b000);
    wr(7'h60, 8'h03);
    wr(7'h58, 8'hc1);
    chk("aux limit disabled", {AUX_SLEW_OUT, AUX_LIMIT_ON_OUT}, 3'b000);
    wr(7'h60, 8'h00);
    // Aux fault with retry off must hold until the config is rewritten
    wr(7'h59, 8'hc0);
    short_aux = 1'b1;
    cyc(140);
    chk("aux trip", {AUX_DRIVE_EN_OUT, IRQ_N_OUT, AUX_LIMIT_LEVEL_OUT, AUX_LIMIT_ON_OUT}, 5'b00111);
    short_aux = 1'b0;
    wr(7'h61, 8'h01);
    wr(7'h58, 8'h01);
    chk("aux rearm", {AUX_DRIVE_EN_OUT, IRQ_N_OUT}, 2'b11);
    wr(7'h57, 8'h00);
    wr(7'h56, 8'h01);
    DRIVER_ENABLE_PIN_IN = 1'b1;
    short_main = 1'b1;
    cyc(120);
    short_main = 1'b0;
    cyc(2);
    short_main = 1'b1;
    cyc(120);
    chk("blank restart", MAIN_DRIVE_EN_OUT, 1'b1);
    cyc(20);
    chk("fault trip", {MAIN_DRIVE_EN_OUT, IRQ_N_OUT}, 2'b00);
    short_main = 1'b0;
    wr(7'h61, 8'h02);
    chk("fault held", {MAIN_DRIVE_EN_OUT, IRQ_N_OUT}, 2'b01);
    wr(7'h56, 8'h01);
    chk("rearm", MAIN_DRIVE_EN_OUT, 1'b1);
    // Both lines retry together so the long off time is paid only once
    wr(7'h57, 8'h01);
    wr(7'h59, 8'h01);
    short_main = 1'b1;
    short_aux = 1'b1;
    cyc(140);
    chk("retry off", {MAIN_DRIVE_EN_OUT, AUX_DRIVE_EN_OUT}, 2'b00);
    short_main = 1'b0;
    short_aux = 1'b0;
    cyc(49800);
    chk("retry wait", {MAIN_DRIVE_EN_OUT, AUX_DRIVE_EN_OUT}, 2'b00);
    cyc(400);
    chk("retry on", {MAIN_DRIVE_EN_OUT, AUX_DRIVE_EN_OUT}, 2'b11);
    RESETN_IN = 1'b0;
    cyc(2);
    chk("mid reset", {obs[14:0], IRQ_N_OUT}, 16'h0001);
    RESETN_IN = 1'b1;
    cyc(2);
    chk("after reset", obs, 16'h0410);
    spi({1'b1, 7'h61, 8'h00}, rd);
    chk("status after reset", rd, 8'h00);
    final_report();
  end
endmodule // line_driver_control_tb_top
`default_nettype wire
